// >>> hdl/dag_cfg.svh
// Address map, opcode field positions and access bank split for the
// data address generator. Definitions only; included by bare name.
`ifndef DAG_CFG_SVH
`define DAG_CFG_SVH

// Opcode fields
`define DAG_FILE_HI      7
`define DAG_ACCESS_BIT   8
`define DAG_DEST_BIT     9
`define DAG_ADDR_HI      11
`define DAG_PAGE_LO      8

// Access bank: low part from page 0, upper part from the SFR page
`define DAG_ACCESS_SPLIT 8'h60
`define DAG_GPR_PAGE     4'h0
`define DAG_SFR_PAGE     4'hF

// Pointer register blocks: eight addresses each, aligned on 8
`define DAG_PTR_BASE0    12'hFE8
`define DAG_PTR_BASE1    12'hFE0
`define DAG_PTR_BASE2    12'hFD8
`define DAG_OFS_LOW      3'h1
`define DAG_OFS_HIGH     3'h2
`define DAG_OFS_PLUSW    3'h3
`define DAG_OFS_PREINC   3'h4
`define DAG_OFS_POSTDEC  3'h5
`define DAG_OFS_POSTINC  3'h6
`define DAG_OFS_PLAIN    3'h7

// Reset values
`define DAG_PTR_RESET    12'h000
`define DAG_BYTE_RESET   8'h00

`endif

// >>> hdl/dag_pkg.sv
// Types shared by the data address generator, its checker and its bench.
// Assumes dag_cfg.svh for all numeric constants.
package dag_pkg;

    // Instruction class as presented by the core decoder
    typedef enum logic [3:0] {
        CLS_NONE      = 4'h0,
        CLS_INHERENT  = 4'h1,
        CLS_LITERAL   = 4'h2,
        CLS_BYTE_DEST = 4'h3,
        CLS_IMPL_REG  = 4'h4,
        CLS_IMPL_ACC  = 4'h5,
        CLS_FULL_MOVE = 4'h6,
        CLS_PROG_JUMP = 4'h7
    } instr_class_t;

    // Pointer action attached to a virtual operand
    typedef enum logic [2:0] {
        VOP_NONE    = 3'h0,
        VOP_PLAIN   = 3'h1,
        VOP_POSTDEC = 3'h2,
        VOP_POSTINC = 3'h3,
        VOP_PREINC  = 3'h4,
        VOP_PLUSW   = 3'h5
    } vop_t;

endpackage

// >>> hdl/data_address_generator.sv
// Operand address generator for the data memory of an 8-bit core.
// Assumes the decoder presents one instruction per valid cycle with its
// class, and that bank register, accumulator and config bit are stable.
//
// Functional notes
// - Byte and bit instructions take the low opcode byte as the file address.
// - With access bit one, the bank register is the top of a 12-bit address.
// - With access bit zero and no indexed offset, the file address maps onto the fixed access bank.
// - The full-address move takes both 12-bit addresses from its words, no bank.
// - Destination bit one sends the result back to the addressed register.
// - Destination bit zero sends the result to the accumulator only.
// - Instructions without a destination bit use a destination fixed by class.
// - Inherent instructions carry no operand and produce no data address.
// - Literal instructions take their operand value from the opcode.
// - Call and jump instructions carry a 20-bit program target.
// - Indexed literal offset is used only while the extended enable is one.
// - Pointer bytes sit in SFR space and are written by direct instructions.
// - Virtual operands access through a pointer with inc, dec or offset.
// - Each pointer is a byte pair whose high byte keeps only four bits.
// - A plain virtual operand uses the pointer as is, ignoring bank and a.
// - Post-dec, post-inc and pre-inc move the whole 12-bit pointer by one.
`timescale 1ns/10ps
`include "dag_cfg.svh"
module data_address_generator (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // Instruction from decoder
    input  wire logic                  instr_valid,
    input  wire dag_pkg::instr_class_t instr_class,
    input  wire logic [15:0]           opcode,
    input  wire logic [15:0]           opcode_second,
    // Core state
    input  wire logic [3:0]            bank_select_register,
    input  wire logic [7:0]            accumulator,
    input  wire logic                  extended_instruction_enable,
    // Register writes from the data path
    input  wire logic                  sfr_wr_en,
    input  wire logic [11:0]           sfr_wr_addr,
    input  wire logic [7:0]            sfr_wr_data,
    // Pointer read back
    input  wire logic [11:0]           sfr_rd_addr,
    output logic [7:0]                 sfr_rd_data,
    // Resolved operand
    output logic                       addr_valid,
    output logic [11:0]                data_addr,
    output logic                       indirect_used,
    output logic                       dest_to_register,
    output logic                       dest_to_accumulator,
    // Literal, inherent and program flow
    output logic                       inherent_valid,
    output logic                       literal_valid,
    output logic [7:0]                 literal_value,
    output logic                       jump_valid,
    output logic [19:0]                jump_target,
    // Full-address move
    output logic                       move_valid,
    output logic [11:0]                move_src_addr,
    output logic [11:0]                move_dst_addr
);

    // ************************************************************
    // Pointer file
    // ************************************************************
    pointer_if pif ();

    pointer_file u_pointer_file (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pif      (pif)
    );

    localparam logic [2:0][11:0] BASE = {`DAG_PTR_BASE2, `DAG_PTR_BASE1,
                                         `DAG_PTR_BASE0};

    // ************************************************************
    // Direct address
    // ************************************************************
    logic [7:0]  file_addr;
    logic        access_bit;
    logic        is_file_op;
    logic        indexed;
    logic [11:0] direct_addr;

    assign file_addr  = opcode[`DAG_FILE_HI:0];
    assign access_bit = opcode[`DAG_ACCESS_BIT];
    assign is_file_op = instr_class == dag_pkg::CLS_BYTE_DEST ||
                        instr_class == dag_pkg::CLS_IMPL_REG  ||
                        instr_class == dag_pkg::CLS_IMPL_ACC;
    assign indexed    = extended_instruction_enable && !access_bit &&
                        file_addr < `DAG_ACCESS_SPLIT;

    always_comb begin
        if (access_bit) begin
            direct_addr = {bank_select_register, file_addr};
        end else if (indexed) begin
            direct_addr = pif.ptr[2] + {4'h0, file_addr};
        end else if (file_addr < `DAG_ACCESS_SPLIT) begin
            direct_addr = {`DAG_GPR_PAGE, file_addr};
        end else begin
            direct_addr = {`DAG_SFR_PAGE, file_addr};
        end
    end

    // ************************************************************
    // Virtual operand decode
    // ************************************************************
    logic [2:0]      hit;
    dag_pkg::vop_t   vop_of [3];

    for (genvar i = 0; i < 3; i++) begin : g_vop
        always_comb begin
            hit[i]    = direct_addr[11:3] == BASE[i][11:3] &&
                        direct_addr[2:0] >= `DAG_OFS_PLUSW;
            vop_of[i] = dag_pkg::VOP_NONE;
            unique case (direct_addr[2:0])
                `DAG_OFS_PLAIN:   vop_of[i] = dag_pkg::VOP_PLAIN;
                `DAG_OFS_POSTINC: vop_of[i] = dag_pkg::VOP_POSTINC;
                `DAG_OFS_POSTDEC: vop_of[i] = dag_pkg::VOP_POSTDEC;
                `DAG_OFS_PREINC:  vop_of[i] = dag_pkg::VOP_PREINC;
                `DAG_OFS_PLUSW:   vop_of[i] = dag_pkg::VOP_PLUSW;
                default:          vop_of[i] = dag_pkg::VOP_NONE;
            endcase
        end
    end

    // ************************************************************
    // Effective address and pointer action
    // ************************************************************
    logic [1:0]    sel;
    dag_pkg::vop_t vop;
    logic [11:0]   sel_ptr;
    logic [11:0]   eff_addr;
    logic          take;

    assign take = instr_valid && is_file_op;

    always_comb begin
        sel = 2'd0;
        if (hit[1]) begin
            sel = 2'd1;
        end else if (hit[2]) begin
            sel = 2'd2;
        end
    end

    assign vop     = (|hit) ? vop_of[sel] : dag_pkg::VOP_NONE;
    assign sel_ptr = pif.ptr[sel];

    // Bank register and access bit play no part once a pointer is used
    always_comb begin
        unique case (vop)
            dag_pkg::VOP_NONE:    eff_addr = direct_addr;
            dag_pkg::VOP_PREINC:  eff_addr = sel_ptr + 12'h001;
            dag_pkg::VOP_PLUSW:   eff_addr = sel_ptr + {{4{accumulator[7]}}, accumulator};
            default:              eff_addr = sel_ptr;
        endcase
    end

    always_comb begin
        pif.adj_en   = 3'b000;
        pif.adj_down = vop == dag_pkg::VOP_POSTDEC;
        if (take && (vop == dag_pkg::VOP_POSTINC || vop == dag_pkg::VOP_POSTDEC ||
                     vop == dag_pkg::VOP_PREINC)) begin
            pif.adj_en[sel] = 1'b1;
        end
    end

    assign pif.wr_en   = sfr_wr_en;
    assign pif.wr_addr = sfr_wr_addr;
    assign pif.wr_data = sfr_wr_data;

    // ************************************************************
    // Output registers
    // ************************************************************
    logic        next_addr_valid;
    logic        next_dest_reg;
    logic        next_dest_acc;
    logic [7:0]  next_rd_data;

    always_comb begin
        next_addr_valid = take;
        next_dest_reg   = 1'b0;
        next_dest_acc   = 1'b0;
        if (take) begin
            unique case (instr_class)
                dag_pkg::CLS_BYTE_DEST: begin
                    next_dest_reg = opcode[`DAG_DEST_BIT];
                    next_dest_acc = !opcode[`DAG_DEST_BIT];
                end
                dag_pkg::CLS_IMPL_REG:  next_dest_reg = 1'b1;
                default:                next_dest_acc = 1'b1;
            endcase
        end
        next_rd_data = `DAG_BYTE_RESET;
        for (int i = 0; i < 3; i++) begin
            if (sfr_rd_addr == (BASE[i] | 12'(`DAG_OFS_LOW))) begin
                next_rd_data = pif.ptr[i][7:0];
            end
            if (sfr_rd_addr == (BASE[i] | 12'(`DAG_OFS_HIGH))) begin
                next_rd_data = {4'h0, pif.ptr[i][11:8]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_valid          <= 1'b0;
            data_addr           <= `DAG_PTR_RESET;
            indirect_used       <= 1'b0;
            dest_to_register    <= 1'b0;
            dest_to_accumulator <= 1'b0;
            inherent_valid      <= 1'b0;
            literal_valid       <= 1'b0;
            literal_value       <= `DAG_BYTE_RESET;
            jump_valid          <= 1'b0;
            jump_target         <= 20'h00000;
            move_valid          <= 1'b0;
            move_src_addr       <= `DAG_PTR_RESET;
            move_dst_addr       <= `DAG_PTR_RESET;
            sfr_rd_data         <= `DAG_BYTE_RESET;
        end else begin
            addr_valid          <= next_addr_valid;
            dest_to_register    <= next_dest_reg;
            dest_to_accumulator <= next_dest_acc;
            sfr_rd_data         <= next_rd_data;
            inherent_valid      <= instr_valid &&
                                   instr_class == dag_pkg::CLS_INHERENT;
            literal_valid       <= instr_valid && instr_class == dag_pkg::CLS_LITERAL;
            jump_valid          <= instr_valid && instr_class == dag_pkg::CLS_PROG_JUMP;
            move_valid          <= instr_valid && instr_class == dag_pkg::CLS_FULL_MOVE;
            if (take) begin
                data_addr     <= eff_addr;
                indirect_used <= vop != dag_pkg::VOP_NONE;
            end
            if (instr_valid && instr_class == dag_pkg::CLS_LITERAL) begin
                literal_value <= opcode[`DAG_FILE_HI:0];
            end
            if (instr_valid && instr_class == dag_pkg::CLS_PROG_JUMP) begin
                jump_target <= {opcode_second[`DAG_ADDR_HI:0],
                                opcode[`DAG_FILE_HI:0]};
            end
            if (instr_valid && instr_class == dag_pkg::CLS_FULL_MOVE) begin
                move_src_addr <= opcode[`DAG_ADDR_HI:0];
                move_dst_addr <= opcode_second[`DAG_ADDR_HI:0];
            end
        end
    end

endmodule

// >>> hdl/pointer_file.sv
// Three 12-bit indirect pointers, each a low/high byte pair.
// Assumes the generator never requests an adjust together with a
// register write to the same pointer unless the write should win.
`timescale 1ns/10ps
`include "dag_cfg.svh"
module pointer_file (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Generator side
    pointer_if.file  pif
);

    localparam logic [2:0][11:0] BASE = {`DAG_PTR_BASE2, `DAG_PTR_BASE1,
                                         `DAG_PTR_BASE0};

    for (genvar i = 0; i < 3; i++) begin : g_ptr
        logic [11:0] ptr;
        logic [11:0] next_ptr;

        // A byte write beats the adjust, so writing a pointer through its
        // own virtual operand stores the value unadjusted.
        always_comb begin
            next_ptr = ptr;
            if (pif.wr_en && pif.wr_addr == (BASE[i] | 12'(`DAG_OFS_LOW))) begin
                next_ptr = {ptr[11:8], pif.wr_data};
            end else if (pif.wr_en && pif.wr_addr == (BASE[i] | 12'(`DAG_OFS_HIGH))) begin
                next_ptr = {pif.wr_data[3:0], ptr[7:0]};
            end else if (pif.adj_en[i]) begin
                // Full 12-bit carry between bytes; no flags touched
                next_ptr = pif.adj_down ? ptr - 12'h001 : ptr + 12'h001;
            end
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                ptr <= `DAG_PTR_RESET;
            end else begin
                ptr <= next_ptr;
            end
        end

        assign pif.ptr[i] = ptr;
    end

endmodule

// >>> hdl/pointer_if.sv
// Carrier between the address generator and its pointer file.
// Assumes one clock; all signals are same-domain.
`timescale 1ns/10ps
interface pointer_if;
    logic [2:0]       adj_en;
    logic             adj_down;
    logic             wr_en;
    logic [11:0]      wr_addr;
    logic [7:0]       wr_data;
    logic [2:0][11:0] ptr;

    modport gen  (output adj_en, output adj_down, output wr_en, output wr_addr,
                  output wr_data, input ptr);
    modport file (input adj_en, input adj_down, input wr_en, input wr_addr,
                  input wr_data, output ptr);
endinterface

// >>> verification/dag_asserts.sv
// Checker for the data address generator top-level ports.
// Assumes it is bound to data_address_generator, one clock domain.
`timescale 1ns/10ps
module dag_asserts (
    // Clock and reset
    input logic                  core_clk,
    input logic                  rst_n,
    // Instruction
    input logic                  instr_valid,
    input dag_pkg::instr_class_t instr_class,
    input logic [15:0]           opcode,
    input logic [15:0]           opcode_second,
    input logic [3:0]            bank_select_register,
    input logic                  extended_instruction_enable,
    // Results
    input logic                  addr_valid,
    input logic [11:0]           data_addr,
    input logic                  indirect_used,
    input logic                  dest_to_register,
    input logic                  dest_to_accumulator,
    input logic                  inherent_valid,
    input logic                  literal_valid,
    input logic [7:0]            literal_value,
    input logic                  jump_valid,
    input logic [19:0]           jump_target,
    input logic                  move_valid,
    input logic [11:0]           move_src_addr,
    input logic [11:0]           move_dst_addr
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire byte_op = instr_valid && instr_class == dag_pkg::CLS_BYTE_DEST;
    a_lit: assert property (instr_valid && instr_class == dag_pkg::CLS_LITERAL
        |=> literal_valid && literal_value == $past(opcode[7:0])) else $error("literal");
    a_inh: assert property (instr_valid && instr_class == dag_pkg::CLS_INHERENT
        |=> inherent_valid && !addr_valid) else $error("inherent");
    a_jump: assert property (instr_valid && instr_class == dag_pkg::CLS_PROG_JUMP
        |=> jump_valid && jump_target == {$past(opcode_second[11:0]), $past(opcode[7:0])})
        else $error("jump target");
    a_move: assert property (instr_valid && instr_class == dag_pkg::CLS_FULL_MOVE
        |=> move_valid && move_src_addr == $past(opcode[11:0])
        && move_dst_addr == $past(opcode_second[11:0])) else $error("move");
    a_bank: assert property (byte_op && opcode[8]
        && {bank_select_register, opcode[7:0]} < 12'hFD8 |=> addr_valid && !indirect_used
        && data_addr == $past({bank_select_register, opcode[7:0]})) else $error("banked");
    a_access: assert property (byte_op && !opcode[8] && opcode[7:0] < 8'h60
        && !extended_instruction_enable |=> data_addr == {4'h0, $past(opcode[7:0])})
        else $error("access");
    a_dest: assert property (byte_op |=> addr_valid
        && dest_to_register == $past(opcode[9]) && dest_to_accumulator != $past(opcode[9]))
        else $error("dest");
    a_impl: assert property (instr_valid && instr_class == dag_pkg::CLS_IMPL_ACC
        |=> dest_to_accumulator && !dest_to_register) else $error("implicit");
endmodule
bind data_address_generator dag_asserts u_dag_asserts (.*);

// >>> verification/data_address_generator_tb_top.sv
// Directed bench for the data address generator.
// Assumes the bound checker and the memory model beside the design.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module data_address_generator_tb_top;
    logic                  core_clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  instr_valid = 1'b0;
    dag_pkg::instr_class_t instr_class = dag_pkg::CLS_NONE;
    logic [15:0]           opcode = 16'h0000;
    logic [15:0]           opcode_second = 16'h0000;
    logic [3:0]            bank_select_register = 4'h0;
    logic [7:0]            accumulator = 8'h00;
    logic                  extended_instruction_enable = 1'b0;
    logic                  sfr_wr_en = 1'b0;
    logic [11:0]           sfr_wr_addr = 12'h000;
    logic [7:0]            sfr_wr_data = 8'h00;
    logic [11:0]           sfr_rd_addr = 12'h000;
    logic [7:0]            sfr_rd_data, literal_value;
    logic                  addr_valid, indirect_used, dest_to_register, dest_to_accumulator;
    logic                  inherent_valid, literal_valid, jump_valid, move_valid;
    logic [11:0]           data_addr, move_src_addr, move_dst_addr, last_addr;
    logic [19:0]           jump_target;
    int                    hits;
    int                    failures = 0;
    int                    comparisons = 0;
    int                    cycles = 0;

    data_address_generator u_data_address_generator (.*);
    data_memory_model u_data_memory_model (.*);

    always #2.5 core_clk = ~core_clk;

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic issue(input dag_pkg::instr_class_t c, input logic [15:0] op,
                         input logic [15:0] op2 = 16'h0000);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_class <= c;
        opcode <= op;
        opcode_second <= op2;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    task automatic fop(input logic [15:0] op, input logic [11:0] a);
        issue(dag_pkg::CLS_BYTE_DEST, op);
        `CHK(addr_valid, 1'b1)
        `CHK(data_addr, a)
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_wr_en <= 1'b1;
        sfr_wr_addr <= a;
        sfr_wr_data <= d;
        @(posedge core_clk);
        sfr_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfr_rd_addr <= a;
        @(posedge core_clk);
        #1;
        `CHK(sfr_rd_data, e)
    endtask
    task automatic wrap_up;
        $display("counts: comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up;
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        `CHK(addr_valid, 1'b0)
        rd(12'hFE9, 8'h00);
        issue(dag_pkg::CLS_LITERAL, 16'h0E5A);
        `CHK(literal_value, 8'h5A)
        issue(dag_pkg::CLS_INHERENT, 16'h0004);
        `CHK({inherent_valid, addr_valid}, 2'h2)
        issue(dag_pkg::CLS_PROG_JUMP, 16'hEF34, 16'hF123);
        `CHK(jump_target, 20'h12334)
        bank_select_register <= 4'h5;
        issue(dag_pkg::CLS_FULL_MOVE, 16'hC456, 16'hF789);
        `CHK({move_src_addr, move_dst_addr}, 24'h456789)
        $display("test fixed modes done");
        bank_select_register <= 4'h3;
        fop(16'h0322, 12'h322);
        `CHK({dest_to_register, dest_to_accumulator, indirect_used}, 3'h4)
        fop(16'h0022, 12'h022);
        `CHK({dest_to_register, dest_to_accumulator}, 2'h1)
        fop(16'h0080, 12'hF80);
        issue(dag_pkg::CLS_IMPL_ACC, 16'h0122);
        `CHK({dest_to_register, dest_to_accumulator}, 2'h1)
        issue(dag_pkg::CLS_IMPL_REG, 16'h0122);
        `CHK({dest_to_register, dest_to_accumulator}, 2'h2)
        $display("test direct done");
        wr(12'hFE9, 8'hFF);
        wr(12'hFEA, 8'hF1);
        rd(12'hFEA, 8'h01);
        rd(12'hFE9, 8'hFF);
        fop(16'h02EE, 12'h1FF);
        `CHK(indirect_used, 1'b1)
        rd(12'hFE9, 8'h00);
        rd(12'hFEA, 8'h02);
        fop(16'h00ED, 12'h200);
        fop(16'h00EC, 12'h200);
        fop(16'h00EF, 12'h200);
        rd(12'hFE9, 8'h00);
        accumulator <= 8'h10;
        fop(16'h00EB, 12'h210);
        accumulator <= 8'hFF;
        fop(16'h00EB, 12'h1FF);
        rd(12'hFE9, 8'h00);
        $display("test indirect done");
        wr(12'hFDA, 8'h03);
        wr(12'hFD9, 8'h00);
        extended_instruction_enable <= 1'b1;
        fop(16'h0005, 12'h305);
        fop(16'h0060, 12'hF60);
        extended_instruction_enable <= 1'b0;
        fop(16'h0005, 12'h005);
        // Model counts the last pulse one edge after the design shows it
        @(posedge core_clk);
        #1;
        `CHK(hits, 14)
        `CHK(last_addr, 12'h005)
        $display("test indexed done");
        wrap_up;
    end
endmodule

// >>> verification/data_memory_model.sv
// Data memory side: records every resolved operand access.
// Assumes addr_valid is a one-cycle pulse per access.
`timescale 1ns/10ps
module data_memory_model (
    // Clock and reset
    input  logic        core_clk,
    input  logic        rst_n,
    // Operand access
    input  logic        addr_valid,
    input  logic [11:0] data_addr,
    // Observation
    output logic [11:0] last_addr,
    output int          hits
);
    // Counts accesses so lost or doubled pulses show up
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hits <= 0;
            last_addr <= 12'h000;
        end else if (addr_valid) begin
            hits <= hits + 1;
            last_addr <= data_addr;
        end
    end
endmodule
